// *** verilog/line_event_irq.sv ***
/*
  Per-channel interrupt edge select and mask block with an APB slave.
  Assumes status inputs are synchronous to pclk and driven by detectors.
*/
// The register addresses and the APB register port are this design's own decisions.
//
// Operation
// R1: Edge-select 0 latches rising edges only; 1 latches either edge.
// R2: Edge-select bit 4 qualifies the over-current status bit.
// R3: Edge-select bit 3 qualifies the transmit-clock-missing status bit.
// R4: Edge-select bit 2 qualifies the transmit loss-of-signal status bit.
// R5: Edge-select bit 1 governs both line and system loss-of-signal.
// R6: Edge-select bit 0 governs both in-band loopback code status bits.
// R7: Mask bit 0 enables, 1 suppresses; all masks reset to 1.
// R8: Mask 0 bit 7 masks the waveform generation interrupt.
// R9: Mask 0 bit 6 masks the transmit jitter FIFO interrupt.
// R10: Mask 0 bit 5 masks the receive jitter FIFO interrupt.
// R11: Mask 0 bit 4 masks the line driver over-current interrupt.
// R12: Mask 0 bit 3 masks the transmit clock missing interrupt.
// R13: Mask 0 bits 2,1,0 mask transmit, system, line loss-of-signal.
// R14: Mask 1 bits 7,6 mask system and line alarm indication.
// R15: Mask 1 bit 5 masks the test pattern detection interrupt.
// R16: Edge-select bits 5 and 6 qualify pattern and alarm indication.
// R17: Masked flags still latch; only unmasked flags raise the request.
`timescale 1ns/1ps
`include "line_irq_map.svh"
module line_event_irq
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic [7:0]  status_reg_0,
  input  wire logic [7:0]  status_reg_1,
  output logic             irq_request
);
  // ==========================================================
  // Registers
  // ==========================================================
  line_irq_pkg::byte_reg_t interrupt_edge_select;
  line_irq_pkg::byte_reg_t interrupt_mask_0;
  line_irq_pkg::byte_reg_t interrupt_mask_1;
  line_irq_pkg::byte_reg_t es0;
  line_irq_pkg::byte_reg_t es1;
  line_irq_pkg::byte_reg_t next_rdata;
  logic                    access;
  logic                    wr;
  logic                    mapped;
  logic                    next_irq;

  event_latch_if lat0 ();
  event_latch_if lat1 ();

  assign access = psel & penable & pready;
  assign wr     = access & pwrite;

  always_comb
  begin
    unique case (paddr)
      `EDGE_SEL_OFFSET, `MASK_0_OFFSET, `MASK_1_OFFSET,
      `STATUS_0_OFFSET, `STATUS_1_OFFSET,
      `IRQ_STATUS_0_OFFSET, `IRQ_STATUS_1_OFFSET: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      interrupt_edge_select <= `EDGE_SEL_RESET;
    else if (wr && paddr == `EDGE_SEL_OFFSET)
      interrupt_edge_select <= {1'b0, pwdata[6:0]};
  end

  // Masks leave reset all ones so every source starts suppressed.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      interrupt_mask_0 <= `MASK_RESET; // [R7]
      interrupt_mask_1 <= `MASK_RESET; // [R7]
    end
    else if (wr && paddr == `MASK_0_OFFSET)
      interrupt_mask_0 <= pwdata[7:0];
    else if (wr && paddr == `MASK_1_OFFSET)
      interrupt_mask_1 <= pwdata[7:0] | ~`MASK_1_USED;
  end

  // ==========================================================
  // Edge qualification
  // ==========================================================
  // Detector bits without an edge-select source latch on rising edges.
  always_comb
  begin
    es0 = 8'h00;
    es0[`S0_LINE_SIGLOSS]  = interrupt_edge_select[`ES_SIGLOSS]; // [R5]
    es0[`S0_SYS_SIGLOSS]   = interrupt_edge_select[`ES_SIGLOSS]; // [R5]
    es0[`S0_TX_SIGLOSS]    = interrupt_edge_select[`ES_TX_SIGLOSS]; // [R4]
    es0[`S0_TXCLK_MISSING] =
      interrupt_edge_select[`ES_TXCLK_MISSING]; // [R3]
    es0[`S0_OVERCURRENT]   = interrupt_edge_select[`ES_OVERCURRENT]; // [R2]
    es1 = 8'h00;
    es1[`S1_INBAND_DEACT]  = interrupt_edge_select[`ES_INBAND]; // [R6]
    es1[`S1_INBAND_ACT]    = interrupt_edge_select[`ES_INBAND]; // [R6]
    es1[`S1_PATTERN]       = interrupt_edge_select[`ES_PATTERN]; // [R16]
    es1[`S1_LINE_ALARM_IND] = interrupt_edge_select[`ES_ALARM_IND]; // [R16]
    es1[`S1_SYS_ALARM_IND]  = interrupt_edge_select[`ES_ALARM_IND]; // [R16]
  end

  assign lat0.state    = status_reg_0;
  assign lat0.any_edge = es0; // [R1]
  assign lat0.clear    = (wr && paddr == `IRQ_STATUS_0_OFFSET)
                         ? pwdata[7:0] : 8'h00;
  assign lat1.state    = status_reg_1;
  assign lat1.any_edge = es1; // [R1]
  assign lat1.clear    = (wr && paddr == `IRQ_STATUS_1_OFFSET)
                         ? pwdata[7:0] : 8'h00;

  event_latch u_latch_0
  (
    .pclk    (pclk),
    .presetn (presetn),
    .lk      (lat0.latch)
  );

  event_latch u_latch_1
  (
    .pclk    (pclk),
    .presetn (presetn),
    .lk      (lat1.latch)
  );

  // ==========================================================
  // Interrupt request
  // ==========================================================
  // Bit-wise masking covers waveform, jitter FIFOs, over-current,
  // clock missing, loss-of-signal, alarm indication and pattern.
  assign next_irq = |(lat0.flags & ~interrupt_mask_0) // [R8] [R9] [R10]
                  | |(lat1.flags & ~interrupt_mask_1); // [R14] [R15] [R17]

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_request <= 1'b0;
    else
      irq_request <= next_irq; // [R11] [R12] [R13]
  end

  // ==========================================================
  // APB slave
  // ==========================================================
  always_comb
  begin
    unique case (paddr)
      `EDGE_SEL_OFFSET:     next_rdata = interrupt_edge_select;
      `MASK_0_OFFSET:       next_rdata = interrupt_mask_0;
      `MASK_1_OFFSET:       next_rdata = interrupt_mask_1;
      `STATUS_0_OFFSET:     next_rdata = status_reg_0;
      `STATUS_1_OFFSET:     next_rdata = status_reg_1;
      `IRQ_STATUS_0_OFFSET: next_rdata = lat0.flags;
      `IRQ_STATUS_1_OFFSET: next_rdata = lat1.flags;
      default:              next_rdata = 8'h00;
    endcase
  end

  // One wait state: pready rises in the second access cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (psel && penable && !pready)
    begin
      pready  <= 1'b1;
      prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, next_rdata};
      pslverr <= ~mapped;
    end
    else
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  mask_reset_a: assert property (@(posedge pclk)
    $rose(presetn) |-> interrupt_mask_0 == 8'hFF
                       && interrupt_mask_1 == 8'hFF) // [R7]
    else $error("masks not all set after reset");

  rise_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(status_reg_0[4]) |=> lat0.flags[4]) // [R2]
    else $error("over-current rise not latched");

  fall_ignored_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(status_reg_0[3]) && !interrupt_edge_select[3] && !lat0.flags[3]
    && !$rose(status_reg_0[3]) |=> !lat0.flags[3]) // [R3]
    else $error("falling edge latched in rising mode");

  fall_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(status_reg_0[2]) && interrupt_edge_select[2]
    |=> lat0.flags[2]) // [R4]
    else $error("tx loss fall not latched");

  los_pair_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(status_reg_0[0]) && interrupt_edge_select[1]
    |=> lat0.flags[0]) // [R5]
    else $error("line loss fall not latched");

  inband_pair_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(status_reg_1[1]) && interrupt_edge_select[0]
    |=> lat1.flags[1]) // [R6]
    else $error("inband activate fall not latched");

  alarm_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(status_reg_1[7]) && interrupt_edge_select[6]
    |=> lat1.flags[7]) // [R16]
    else $error("alarm fall not latched");

  masked_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    (lat0.flags & ~interrupt_mask_0) == 8'h00
    && (lat1.flags & ~interrupt_mask_1) == 8'h00 |=> !irq_request) // [R17]
    else $error("request raised while all flags masked");

  unmasked_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
    lat0.flags[7] && !interrupt_mask_0[7] |=> irq_request) // [R8]
    else $error("waveform flag did not raise request");

  pattern_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
    lat1.flags[5] && !interrupt_mask_1[5] |=> irq_request) // [R15]
    else $error("pattern flag did not raise request");

  // Bus answer: one wait state, a one-cycle pready, error only with it.
  ready_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pready |=> pready)
    else $error("pready missing after first access cycle");

  ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("pready held for more than one cycle");

  ready_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(psel && penable) |=> !pready)
    else $error("pready raised outside an access phase");

  unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pready && !mapped |=> pslverr)
    else $error("unmapped access without slave error");

  mapped_ok_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pready && mapped |=> !pslverr)
    else $error("slave error on a mapped register");

  err_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("slave error outside the ready cycle");

  write_rdata_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pready && pwrite |=> prdata == 32'h0000_0000)
    else $error("read data not zero on a write");

  rdata_upper_a: assert property (@(posedge pclk) disable iff (!presetn)
    prdata[31:8] == 24'h00_0000)
    else $error("unused read data bits not zero");

  // Register fields, per-source request masking and flag lifetime.
  es_reserved_a: assert property (@(posedge pclk) disable iff (!presetn)
    !interrupt_edge_select[7])
    else $error("reserved edge-select bit set");

  es_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == `EDGE_SEL_OFFSET
    |=> interrupt_edge_select[6:0] == $past(pwdata[6:0])) // [R1]
    else $error("edge-select write not taken");

  mask1_spare_a: assert property (@(posedge pclk) disable iff (!presetn)
    interrupt_mask_1[4:0] == 5'h1F) // [R7]
    else $error("unused mask 1 bits not all set");

  mask_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == `MASK_0_OFFSET
    |=> interrupt_mask_0 == $past(pwdata[7:0])) // [R7]
    else $error("mask 0 write not taken");

  tx_fifo_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
    lat0.flags[6] && !interrupt_mask_0[6] |=> irq_request) // [R9]
    else $error("transmit jitter FIFO flag did not raise request");

  rx_fifo_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
    lat0.flags[5] && !interrupt_mask_0[5] |=> irq_request) // [R10]
    else $error("receive jitter FIFO flag did not raise request");

  overcurrent_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
    lat0.flags[4] && !interrupt_mask_0[4] |=> irq_request) // [R11]
    else $error("over-current flag did not raise request");

  txclk_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
    lat0.flags[3] && !interrupt_mask_0[3] |=> irq_request) // [R12]
    else $error("clock missing flag did not raise request");

  sigloss_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
    (lat0.flags[2:0] & ~interrupt_mask_0[2:0]) != 3'h0
    |=> irq_request) // [R13]
    else $error("loss-of-signal flag did not raise request");

  alarm_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
    (lat1.flags[7:6] & ~interrupt_mask_1[7:6]) != 2'h0
    |=> irq_request) // [R14]
    else $error("alarm indication flag did not raise request");

  masked_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(status_reg_0[0]) && interrupt_mask_0[0]
    |=> lat0.flags[0]) // [R17]
    else $error("masked source did not latch its flag");

  flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    lat0.flags[7] && !lat0.clear[7] |=> lat0.flags[7]) // [R17]
    else $error("flag dropped without a clear");

  flag_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    lat0.clear[7] && !$rose(status_reg_0[7]) |=> !lat0.flags[7]) // [R17]
    else $error("flag survived its clear");

  pattern_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(status_reg_1[5]) && interrupt_edge_select[5]
    |=> lat1.flags[5]) // [R16]
    else $error("pattern fall not latched");

  write_cov: cover property (@(posedge pclk) wr);
  fifo_cov: cover property (@(posedge pclk)
    lat0.flags[6] && !interrupt_mask_0[6]);
  irq_cov: cover property (@(posedge pclk) $rose(irq_request));
  clear_cov: cover property (@(posedge pclk) lat0.clear != 8'h00);
  anyedge_cov: cover property (@(posedge pclk)
    $fell(status_reg_0[4]) && interrupt_edge_select[4]);
endmodule : line_event_irq

// *** verilog/line_irq_map.svh ***
/*
  Register offsets, field positions and reset values of the line event
  interrupt block. Assumes it is included by bare name.
*/
`ifndef LINE_IRQ_MAP_SVH
`define LINE_IRQ_MAP_SVH

`define EDGE_SEL_OFFSET    12'h000
`define MASK_0_OFFSET      12'h004
`define MASK_1_OFFSET      12'h008
`define STATUS_0_OFFSET    12'h00C
`define STATUS_1_OFFSET    12'h010
`define IRQ_STATUS_0_OFFSET 12'h014
`define IRQ_STATUS_1_OFFSET 12'h018

`define EDGE_SEL_RESET     8'h00
`define MASK_RESET         8'hFF

`define ES_INBAND          0
`define ES_SIGLOSS         1
`define ES_TX_SIGLOSS      2
`define ES_TXCLK_MISSING   3
`define ES_OVERCURRENT     4
`define ES_PATTERN         5
`define ES_ALARM_IND       6

`define S0_LINE_SIGLOSS    0
`define S0_SYS_SIGLOSS     1
`define S0_TX_SIGLOSS      2
`define S0_TXCLK_MISSING   3
`define S0_OVERCURRENT     4
`define S0_RX_JITTER_FIFO  5
`define S0_TX_JITTER_FIFO  6
`define S0_WAVEFORM        7

`define S1_INBAND_DEACT    0
`define S1_INBAND_ACT      1
`define S1_PATTERN         5
`define S1_LINE_ALARM_IND  6
`define S1_SYS_ALARM_IND   7

`define S0_EDGE_MASK       8'h1F
`define S1_EDGE_MASK       8'hE3
`define MASK_1_USED        8'hE0

`endif

// *** verilog/line_irq_pkg.sv ***
/*
  Types shared by the line event interrupt block.
  Assumes nothing of its surroundings.
*/
package line_irq_pkg;
  typedef logic [7:0] byte_reg_t;
endpackage : line_irq_pkg

// *** verilog/event_latch_if.sv ***
/*
  Carrier between the top module and one eight-bit latch group.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
interface event_latch_if;
  line_irq_pkg::byte_reg_t state;
  line_irq_pkg::byte_reg_t any_edge;
  line_irq_pkg::byte_reg_t clear;
  line_irq_pkg::byte_reg_t flags;
  modport owner
  (
    output state,
    output any_edge,
    output clear,
    input  flags
  );
  modport latch
  (
    input  state,
    input  any_edge,
    input  clear,
    output flags
  );
endinterface : event_latch_if

// *** verilog/event_latch.sv ***
/*
  Eight edge-qualified sticky interrupt flags.
  Assumes state bits are synchronous to pclk.
*/
`timescale 1ns/1ps
module event_latch
(
  input wire logic   pclk,
  input wire logic   presetn,
  event_latch_if.latch lk
);
  line_irq_pkg::byte_reg_t prev;
  line_irq_pkg::byte_reg_t hit;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prev <= 8'h00;
    else
      prev <= lk.state;
  end

  // Rising edges always count; falling ones only when any_edge is set.
  assign hit = (lk.state & ~prev) | (lk.any_edge & prev & ~lk.state); // [R1]

  // Set wins over a clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lk.flags <= 8'h00;
    else
      lk.flags <= (lk.flags & ~lk.clear) | hit; // [R17]
  end
endmodule : event_latch

// *** tb/testbench.sv ***
/*
  Self-checking bench for the line event interrupt block: APB tasks,
  edge select, flag latching and per-bit masking.
  Assumes the design files and the register map header are compiled first.
*/
`timescale 1ns/1ps
`include "line_irq_map.svh"
module testbench;
  logic                    pclk;
  logic                    presetn;
  logic                    psel;
  logic                    penable;
  logic                    pwrite;
  logic [11:0]             paddr;
  logic [31:0]             pwdata;
  logic                    pready;
  logic [31:0]             prdata;
  logic                    pslverr;
  line_irq_pkg::byte_reg_t status_reg_0;
  line_irq_pkg::byte_reg_t status_reg_1;
  logic                    irq_request;
  logic [31:0]             rd;
  logic                    err;
  logic [7:0]              s;
  logic [11:0]             ma;
  logic [11:0]             ia;
  int                      n_fail;
  int                      comparisons;

  // Flags that a falling edge sets when only edge-select bit k is 1.
  localparam logic [7:0] ES_S0 [7] =
    '{8'h00, 8'h03, 8'h04, 8'h08, 8'h10, 8'h00, 8'h00};
  localparam logic [7:0] ES_S1 [7] =
    '{8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'hC0};

  line_event_irq dut_u
  (
    .pclk         (pclk),
    .presetn      (presetn),
    .psel         (psel),
    .penable      (penable),
    .pwrite       (pwrite),
    .paddr        (paddr),
    .pwdata       (pwdata),
    .pready       (pready),
    .prdata       (prdata),
    .pslverr      (pslverr),
    .status_reg_0 (status_reg_0),
    .status_reg_1 (status_reg_1),
    .irq_request  (irq_request)
  );

  always #4 pclk = ~pclk;

  // ==========================================================================
  // Tasks.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict;
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  // One APB transfer; values read right after the edge are pre-edge values.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
    begin
      n_fail++;
      $display("Timeout waiting for pready");
      print_verdict();
    end
    else
    begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp,
                        input logic e);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
    check({31'h0, err}, {31'h0, e});
  endtask : rd_chk

  // Flag follows one edge after the status, the request one edge later.
  task automatic set_status(input logic [7:0] s0, input logic [7:0] s1);
    @(posedge pclk);
    status_reg_0 <= s0;
    status_reg_1 <= s1;
    repeat (3) @(posedge pclk);
  endtask : set_status

  task automatic clear_flags;
    wr(`IRQ_STATUS_0_OFFSET, 32'h0000_00FF);
    wr(`IRQ_STATUS_1_OFFSET, 32'h0000_00FF);
  endtask : clear_flags

  // ==========================================================================
  // Main sequence.
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    status_reg_0 = 8'h00;
    status_reg_1 = 8'h00;
    n_fail = 0;
    comparisons = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(`EDGE_SEL_OFFSET, 32'h0000_0000, 1'b0);
    rd_chk(`MASK_0_OFFSET, 32'h0000_00FF, 1'b0);
    rd_chk(`MASK_1_OFFSET, 32'h0000_00FF, 1'b0);
    rd_chk(12'h0FC, 32'h0000_0000, 1'b1);
    $display("test reset_values done");
    set_status(8'hFF, 8'hE3);
    rd_chk(`IRQ_STATUS_0_OFFSET, 32'h0000_00FF, 1'b0);
    rd_chk(`IRQ_STATUS_1_OFFSET, 32'h0000_00E3, 1'b0);
    check({31'h0, irq_request}, 32'h0000_0000);
    clear_flags();
    set_status(8'h00, 8'h00);
    rd_chk(`IRQ_STATUS_0_OFFSET, 32'h0000_0000, 1'b0);
    rd_chk(`IRQ_STATUS_1_OFFSET, 32'h0000_0000, 1'b0);
    for (int k = 0; k < 7; k++)
    begin
      wr(`EDGE_SEL_OFFSET, 32'h1 << k);
      set_status(8'hFF, 8'hE3);
      clear_flags();
      set_status(8'h00, 8'h00);
      rd_chk(`IRQ_STATUS_0_OFFSET, {24'h0, ES_S0[k]}, 1'b0);
      rd_chk(`IRQ_STATUS_1_OFFSET, {24'h0, ES_S1[k]}, 1'b0);
      clear_flags();
    end
    wr(`EDGE_SEL_OFFSET, 32'h0000_0000);
    $display("test edge_select done");
    // Entries 8 to 10 walk mask register 1 bits 5 to 7.
    for (int i = 0; i < 11; i++)
    begin
      s = 8'h01 << ((i < 8) ? i : i - 3);
      ma = (i < 8) ? `MASK_0_OFFSET : `MASK_1_OFFSET;
      ia = (i < 8) ? `IRQ_STATUS_0_OFFSET : `IRQ_STATUS_1_OFFSET;
      set_status((i < 8) ? s : 8'h00, (i < 8) ? 8'h00 : s);
      check({31'h0, irq_request}, 32'h0000_0000);
      rd_chk(ia, {24'h0, s}, 1'b0);
      wr(ma, {24'h0, ~s});
      rd_chk(ma, {24'h0, ~s}, 1'b0);
      check({31'h0, irq_request}, 32'h0000_0001);
      wr(ma, 32'h0000_00FF);
      repeat (2) @(posedge pclk);
      check({31'h0, irq_request}, 32'h0000_0000);
      set_status(8'h00, 8'h00);
      clear_flags();
    end
    $display("test mask_bits done");
    print_verdict();
  end
endmodule : testbench
